//--- rtl/phy_link_cfg.svh
// Constants for the PHY link request and status block
`ifndef PHY_LINK_CFG_SVH
`define PHY_LINK_CFG_SVH

// ----------------------------------------
// Register bus map
// ----------------------------------------
`define OFF_STATUS    32'h0000_0000
`define OFF_REG_BASE  32'h0000_0040
`define REG_WIN_MASK  32'hFFFF_FFC3

// ----------------------------------------
// Request stream types
// ----------------------------------------
`define REQ_IMM   3'h0
`define REQ_ISO   3'h1
`define REQ_PRI   3'h2
`define REQ_FAIR  3'h3
`define REQ_RD    3'h4
`define REQ_WR    3'h5
`define REQ_ACC   3'h6

// ----------------------------------------
// Request stream bit indexes
// ----------------------------------------
`define IDX_TYPE       5'h03
`define IDX_BUS_STOP   5'h07
`define IDX_BUS_SHORT  5'h06
`define IDX_RD_STOP    5'h08
`define IDX_WR_STOP    5'h10
`define IDX_ACC_STOP   5'h05

// ----------------------------------------
// Interface control codes and status
// ----------------------------------------
`define CTL_IDLE     2'h0
`define CTL_STATUS   2'h1
`define CTL_RECEIVE  2'h2
`define CTL_GRANT    2'h3
`define ST_LEN_FLAGS 4'h2
`define ST_LEN_FULL  4'h8

// ----------------------------------------
// PHY register file
// ----------------------------------------
`define REG_NODE_ID   4'h0
`define REG_ACCEL     4'h5
`define ACCEL_EN_POS  1
`define PHY_REG_RST   8'h00

`endif

//--- rtl/phy_link_pkg.sv
// Types for the PHY link request and status block
package phy_link_pkg;

    typedef enum logic [0:0] {
        RQ_IDLE = 1'b0,
        RQ_BITS = 1'b1
    } rq_state_t;

    typedef enum logic [0:0] {
        S_IDLE = 1'b0,
        S_SEND = 1'b1
    } st_state_t;

endpackage : phy_link_pkg

//--- rtl/phy_link_request_status.sv
// PHY side request decoder, status transfers and register bus
`timescale 1ns/1ps
`include "phy_link_cfg.svh"

module phy_link_request_status
    import phy_link_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        link_request_line,
    input  wire logic        rx_active,
    input  wire logic        link_busy,
    input  wire logic        arb_won,
    input  wire logic        arb_lost,
    input  wire logic        bus_reset_entered,
    input  wire logic        self_id_done,
    input  wire logic        arb_reset_gap,
    input  wire logic        subaction_gap,
    input  wire logic        config_timeout,
    input  wire logic        cable_power_low,
    input  wire logic        state_timeout,
    input  wire logic        port_change,
    output logic [1:0]       interface_control_lines,
    output logic [1:0]       status_data,
    output logic             bus_pending,
    output logic [2:0]       bus_type,
    output logic [2:0]       bus_speed,
    output logic             accel_on
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    rq_state_t   rq_state;
    logic [4:0]  rq_cnt;
    logic [15:0] rq_sr;
    logic [2:0]  rq_type;
    logic [15:0] next_sr;
    logic        rq_done;
    logic        bus_req;
    logic        rd_req;
    logic        wr_req;
    logic        acc_req;
    logic        rx_q;
    logic        gnt_busy;
    logic        grant_now;
    logic        lost_now;
    logic        bus_clear;
    logic [7:0]  phy_reg [0:15];
    logic        rd_pending;
    logic [3:0]  rd_addr;
    logic        sid_pending;
    logic        accel_allow;
    logic        next_allow;
    logic [3:0]  flags;
    logic [3:0]  flag_set;
    logic [3:0]  flag_clr;
    st_state_t   st_state;
    logic [15:0] st_word;
    logic [3:0]  st_len;
    logic [3:0]  st_cnt;
    logic        st_rd;
    logic        st_reg;
    logic        rep_now;
    logic [3:0]  rep_addr;
    logic        st_start;
    logic        st_drive;
    logic        reg_sent;
    logic        ahb_wr;
    logic [31:0] ahb_wa;
    logic [31:0] status_word;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic is_bus(input logic [2:0] t);
        return !t[2];
    endfunction : is_bus

    function automatic logic phy_hit(input logic [31:0] a);
        return (a & `REG_WIN_MASK) == `OFF_REG_BASE;
    endfunction : phy_hit

    function automatic logic req_last(input logic [2:0] t,
                                      input logic [4:0] c,
                                      input logic       b);
        case (t)
            `REQ_RD:  return c == `IDX_RD_STOP;
            `REQ_WR:  return c == `IDX_WR_STOP;
            `REQ_ACC: return c == `IDX_ACC_STOP;
            3'h7:     return c == `IDX_ACC_STOP;
            default:  return c == `IDX_BUS_STOP ||
                             (c == `IDX_BUS_SHORT && !b);
        endcase
    endfunction : req_last

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // ----------------------------------------
    // Request stream receiver
    // ----------------------------------------
    always_comb begin
        next_sr = {rq_sr[14:0], link_request_line};
        rq_done = rq_state == RQ_BITS && rq_cnt > `IDX_TYPE &&
                  req_last(rq_type, rq_cnt, link_request_line);
        bus_req = rq_done && is_bus(rq_type);
        rd_req  = rq_done && rq_type == `REQ_RD;
        wr_req  = rq_done && rq_type == `REQ_WR;
        acc_req = rq_done && rq_type == `REQ_ACC;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rq_state <= RQ_IDLE;
            rq_cnt   <= 5'h00;
            rq_sr    <= 16'h0000;
            rq_type  <= 3'h0;
        end else begin
            case (rq_state)
                RQ_IDLE: begin
                    if (link_request_line) begin
                        rq_state <= RQ_BITS;
                        rq_cnt   <= 5'h01;
                        rq_sr    <= next_sr;
                    end
                end
                RQ_BITS: begin
                    rq_sr  <= next_sr;
                    rq_cnt <= rq_cnt + 5'h01;
                    if (rq_cnt == `IDX_TYPE) begin
                        rq_type <= next_sr[2:0];
                    end
                    if (rq_done) begin
                        rq_state <= RQ_IDLE;
                    end
                end
                default: rq_state <= RQ_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Bus request and grant
    // ----------------------------------------
    always_comb begin
        grant_now = bus_pending &&
                    ((bus_type == `REQ_IMM && rx_q && !rx_active) ||
                     (bus_type != `REQ_IMM && arb_won && !rx_active));
        lost_now  = bus_pending && (arb_lost ||
                    (rx_active &&
                     (bus_type == `REQ_FAIR || bus_type == `REQ_PRI)));
        bus_clear = bus_reset_entered || grant_now || lost_now;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_pending <= 1'b0;
            bus_type    <= 3'h0;
            bus_speed   <= 3'h0;
            rx_q        <= 1'b0;
            gnt_busy    <= 1'b0;
        end else begin
            rx_q     <= rx_active;
            gnt_busy <= grant_now;
            if (bus_clear) begin
                bus_pending <= 1'b0;
            end else if (bus_req && !bus_pending) begin
                bus_pending <= 1'b1;
                bus_type    <= rq_type;
                bus_speed   <= rq_cnt == `IDX_BUS_STOP ?
                               next_sr[3:1] : next_sr[2:0];
            end
        end
    end

    // ----------------------------------------
    // PHY register file
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 16; i++) begin
                phy_reg[i] <= `PHY_REG_RST;
            end
        end else begin
            if (wr_req) begin
                phy_reg[next_sr[12:9]] <= next_sr[8:1];
            end
            if (ahb_wr && phy_hit(ahb_wa)) begin
                phy_reg[ahb_wa[5:2]] <= hwdata[7:0];
            end
        end
    end

    // ----------------------------------------
    // Register read and self-ID report
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_pending  <= 1'b0;
            rd_addr     <= 4'h0;
            sid_pending <= 1'b0;
        end else begin
            if (reg_sent && st_rd) begin
                rd_pending <= 1'b0;
            end
            if (rd_req && !rd_pending) begin
                rd_pending <= 1'b1;
                rd_addr    <= next_sr[4:1];
            end
            if (reg_sent && !st_rd) begin
                sid_pending <= 1'b0;
            end
            if (self_id_done) begin
                sid_pending <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Arbitration acceleration
    // ----------------------------------------
    always_comb begin
        next_allow = acc_req ? next_sr[1] : accel_allow;
        if (bus_reset_entered ||
            (bus_req && !bus_pending && rq_type == `REQ_ISO)) begin
            next_allow = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            accel_allow <= 1'b1;
            accel_on    <= 1'b0;
        end else begin
            accel_allow <= next_allow;
            accel_on <= phy_reg[`REG_ACCEL][`ACCEL_EN_POS] & next_allow;
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    always_comb begin
        flag_set = {config_timeout | cable_power_low |
                    state_timeout | port_change,
                    bus_reset_entered, subaction_gap, arb_reset_gap};
        flag_clr = 4'h0;
        if (st_start) begin
            flag_clr[1:0] = flags[1:0];
        end
        if (st_drive && st_cnt == 4'h1) begin
            flag_clr[3:2] = st_word[3:2];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags <= 4'h0;
        end else begin
            flags <= (flags & ~flag_clr) | flag_set;
        end
    end

    // ----------------------------------------
    // Status transfer
    // ----------------------------------------
    always_comb begin
        rep_now  = rd_pending || sid_pending;
        rep_addr = rd_pending ? rd_addr : `REG_NODE_ID;
        st_start = st_state == S_IDLE &&
                   interface_control_lines == `CTL_IDLE &&
                   !rx_active && !link_busy && !gnt_busy &&
                   !grant_now && (flags != 4'h0 || rep_now);
        st_drive = st_state == S_SEND && !rx_active && !grant_now &&
                   st_cnt != st_len;
        // register counts when last chunk sent
        reg_sent = st_drive && st_reg && st_cnt == st_len - 4'h1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_state <= S_IDLE;
            st_word  <= 16'h0000;
            st_len   <= `ST_LEN_FLAGS;
            st_cnt   <= 4'h0;
            st_rd    <= 1'b0;
            st_reg   <= 1'b0;
        end else begin
            case (st_state)
                S_IDLE: begin
                    if (st_start) begin
                        st_state <= S_SEND;
                        st_word  <= {phy_reg[rep_addr], rep_addr, flags};
                        st_len   <= rep_now ? `ST_LEN_FULL
                                            : `ST_LEN_FLAGS;
                        st_cnt   <= 4'h1;
                        st_rd    <= rd_pending;
                        st_reg   <= rep_now;
                    end
                end
                S_SEND: begin
                    // receive or grant aborts, retry later
                    if (rx_active || grant_now || st_cnt == st_len) begin
                        st_state <= S_IDLE;
                    end else begin
                        st_cnt <= st_cnt + 4'h1;
                    end
                end
                default: st_state <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Interface control and data lines
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            interface_control_lines <= `CTL_IDLE;
            status_data             <= 2'h0;
        end else if (rx_active) begin
            interface_control_lines <= `CTL_RECEIVE;
            status_data             <= 2'h3;
        end else if (grant_now) begin
            interface_control_lines <= `CTL_GRANT;
            status_data             <= 2'h0;
        end else if (st_start) begin
            interface_control_lines <= `CTL_STATUS;
            status_data             <= flags[1:0];
        end else if (st_drive) begin
            interface_control_lines <= `CTL_STATUS;
            status_data <= st_word[{st_cnt[2:0], 1'b0} +: 2];
        end else begin
            interface_control_lines <= `CTL_IDLE;
            status_data             <= 2'h0;
        end
    end

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    assign status_word = {20'h0, flags, 1'b0, accel_on, sid_pending,
                          rd_pending, bus_type, bus_pending};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
            ahb_wr    <= 1'b0;
            ahb_wa    <= 32'h0000_0000;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            ahb_wr    <= hsel && htrans[1] && hready && hwrite &&
                         hsize == 3'h2;
            ahb_wa    <= haddr;
            if (hsel && htrans[1] && hready && !hwrite) begin
                if (phy_hit(haddr) && ahb_wr && phy_hit(ahb_wa) &&
                    haddr[5:2] == ahb_wa[5:2]) begin
                    // Forward a write still in its data phase
                    hrdata <= {24'h0, hwdata[7:0]};
                end else if (phy_hit(haddr)) begin
                    hrdata <= {24'h0, phy_reg[haddr[5:2]]};
                end else if (haddr == `OFF_STATUS) begin
                    hrdata <= status_word;
                end else begin
                    hrdata <= 32'h0000_0000;
                end
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_full;
        st_start && rep_now ##1 (!rx_active && !grant_now) [*8];
    endsequence

    sequence s_short;
        st_start && !rep_now ##1 (!rx_active && !grant_now) [*2];
    endsequence

    a_imm_grant: assert property (
        bus_pending && bus_type == `REQ_IMM && $fell(rx_active)
        |=> interface_control_lines == `CTL_GRANT)
        else $error("immediate grant missing at packet end");

    a_bus_hold: assert property (
        bus_pending && !bus_clear |=> bus_pending && $stable(bus_type))
        else $error("pending bus request changed");

    a_reset_clear: assert property (
        bus_reset_entered |=> !bus_pending)
        else $error("bus reset left a request pending");

    a_reg_write: assert property (
        wr_req && !ahb_wr
        |=> phy_reg[$past(next_sr[12:9])] == $past(next_sr[8:1]))
        else $error("register write not stored");

    a_read_retry: assert property (
        rd_pending && rx_active |=> rd_pending)
        else $error("read dropped during receive");

    a_read_lock: assert property (
        rd_pending && rd_req |=> $stable(rd_addr))
        else $error("second read accepted");

    a_accel_reset: assert property (
        bus_reset_entered && phy_reg[`REG_ACCEL][`ACCEL_EN_POS] &&
        !wr_req && !ahb_wr |=> accel_on)
        else $error("acceleration not re-enabled");

    a_status_gap: assert property (
        interface_control_lines == `CTL_STATUS &&
        $past(interface_control_lines) != `CTL_STATUS
        |-> $past(interface_control_lines) == `CTL_IDLE)
        else $error("status started without idle gap");

    a_full_len: assert property (
        s_full |=> interface_control_lines == `CTL_IDLE &&
        $past(interface_control_lines) == `CTL_STATUS &&
        $past(interface_control_lines, 8) == `CTL_STATUS)
        else $error("register transfer not 8 cycles");

    a_short_len: assert property (
        s_short |=> interface_control_lines == `CTL_IDLE)
        else $error("flags transfer not 2 cycles");

endmodule : phy_link_request_status

//--- sim/link_model.sv
// Link-layer model driving the request stream and taking grants
`timescale 1ns/1ps
module link_model (
    input  wire logic       hclk,
    input  wire logic [1:0] interface_control_lines,
    output logic            link_request_line,
    output logic            link_busy
);
    logic drop_grant = 1'b0;

    initial link_request_line = 1'b0;
    initial link_busy = 1'b0;

    // ----------------------------------------
    // Request stream
    // ----------------------------------------
    // serial word, MSB first
    task automatic send(input logic [16:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge hclk);
            link_request_line <= v[i];
        end
        @(posedge hclk);
        link_request_line <= 1'b0;
    endtask : send

    // ----------------------------------------
    // Grant handling
    // ----------------------------------------
    // bad header drops grant
    always @(posedge hclk) begin
        if (interface_control_lines === 2'h3) begin
            link_busy <= !drop_grant;
            repeat (3) @(posedge hclk);
            link_busy <= 1'b0;
        end
    end
endmodule : link_model

//--- sim/phy_link_request_status_tb_top.sv
// Self-checking bench for the PHY request and status block
`timescale 1ns/1ps
module phy_link_request_status_tb_top;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        rx_active;
    logic [9:0]  ev;
    logic [1:0]  interface_control_lines;
    logic [1:0]  status_data;
    logic        bus_pending;
    logic [2:0]  bus_type;
    logic [2:0]  bus_speed;
    logic        accel_on;
    logic        link_request_line;
    logic        link_busy;
    logic [31:0] rd;
    logic [15:0] w;
    int          n;
    int          n_mismatch = 0;
    int          num_checks = 0;

    phy_link_request_status u_dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .link_request_line, .rx_active, .link_busy,
        .arb_won(ev[8]), .arb_lost(ev[9]), .bus_reset_entered(ev[2]),
        .self_id_done(ev[3]), .arb_reset_gap(ev[0]), .subaction_gap(ev[1]),
        .config_timeout(ev[4]), .cable_power_low(ev[5]),
        .state_timeout(ev[6]), .port_change(ev[7]),
        .interface_control_lines, .status_data, .bus_pending, .bus_type,
        .bus_speed, .accel_on
    );

    link_model u_link (
        .hclk, .interface_control_lines, .link_request_line, .link_busy
    );

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", s, exp, seen);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude

    task automatic ahb(input logic wr, input logic [31:0] a, d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task automatic pulse(input int i);
        @(posedge hclk);
        ev[i] <= 1'b1;
        @(posedge hclk);
        ev[i] <= 1'b0;
    endtask : pulse

    task automatic wait_ctl(input logic [1:0] v);
        int k;
        k = 0;
        @(negedge hclk);
        while (interface_control_lines !== v && k < 60) begin
            @(negedge hclk);
            k++;
        end
    endtask : wait_ctl

    task automatic st();
        w = '0;
        n = 0;
        wait_ctl(2'h1);
        while (interface_control_lines === 2'h1 && n < 8) begin
            w[2*n +: 2] = status_data;
            n++;
            @(negedge hclk);
        end
    endtask : st

    task automatic rx(input int c);
        @(posedge hclk);
        rx_active <= 1'b1;
        repeat (c) @(posedge hclk);
        rx_active <= 1'b0;
    endtask : rx

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = '0;
        rx_active = 1'b0;
        ev = '0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        chk("reset", {hreadyout, hresp, interface_control_lines,
            bus_pending, accel_on}, 32'h20);
        ahb(1'b1, 32'h4C, 32'hA5);
        ahb(1'b0, 32'h4C, 32'h0);
        chk("ahb reg3", rd, 32'hA5);
        ahb(1'b0, 32'h100, 32'h0);
        chk("unmapped", rd, 32'h0);
        u_link.send(17'h1A478, 17);
        ahb(1'b0, 32'h48, 32'h0);
        chk("link write", rd, 32'h3C);
        u_link.send(17'h184, 9);
        st();
        chk("read word", w, 32'h3C20);
        chk("read len", n, 32'd8);
        for (int i = 0; i < 8; i++) begin
            if (i == 2 || i == 3) continue;
            pulse(i);
            st();
            chk("flags", w, (i < 2) ? (32'h1 << i) : 32'h8);
            chk("flags len", n, 32'd2);
        end
        pulse(3);
        st();
        chk("self id", {n[15:0], w}, {16'd8, 16'h0});
        u_link.send(17'hB0, 8);
        u_link.send(17'h98, 8);
        @(negedge hclk);
        chk("fair held", {bus_pending, bus_type}, 32'hB);
        ahb(1'b0, 32'h0, 32'h0);
        chk("status reg", rd, 32'h7);
        rx(3);
        @(negedge hclk);
        chk("rx clears", bus_pending, 32'h0);
        u_link.send(17'h98, 8);
        @(negedge hclk);
        chk("iso", {bus_pending, bus_type, bus_speed}, 32'h4C);
        pulse(2);
        @(negedge hclk);
        chk("reset clears", bus_pending, 32'h0);
        st();
        chk("reset flag", w, 32'h4);
        u_link.send(17'hA4, 8);
        pulse(8);
        wait_ctl(2'h3);
        chk("grant", interface_control_lines, 32'h3);
        @(negedge hclk);
        chk("won clears", bus_pending, 32'h0);
        u_link.drop_grant = 1'b1;
        @(posedge hclk);
        rx_active <= 1'b1;
        u_link.send(17'h80, 8);
        rx_active <= 1'b0;
        wait_ctl(2'h3);
        chk("imm grant", interface_control_lines, 32'h3);
        ahb(1'b1, 32'h54, 32'h2);
        repeat (2) @(negedge hclk);
        chk("accel en", accel_on, 32'h1);
        u_link.send(17'h38, 6);
        @(negedge hclk);
        chk("accel off", accel_on, 32'h0);
        u_link.send(17'h98, 8);
        @(negedge hclk);
        chk("iso re-en", accel_on, 32'h1);
        pulse(9);
        @(negedge hclk);
        chk("lost clears", bus_pending, 32'h0);
        u_link.send(17'h38, 6);
        pulse(2);
        @(negedge hclk);
        chk("reset re-en", accel_on, 32'h1);
        st();
        @(posedge hclk);
        rx_active <= 1'b1;
        u_link.send(17'h186, 9);
        u_link.send(17'h184, 9);
        pulse(2);
        rx_active <= 1'b0;
        st();
        chk("read kept", {n[15:0], w}, {16'd8, 16'hA534});
        st();
        chk("second read", n, 32'd0);
        u_link.send(17'h186, 9);
        wait_ctl(2'h1);
        rx(3);
        st();
        chk("retry", {n[15:0], w}, {16'd8, 16'hA530});
        conclude();
    end

    initial begin
        #200000;
        n_mismatch++;
        conclude();
    end
endmodule : phy_link_request_status_tb_top
